// *** verilog/asr_pkg.sv ***
// Package: constants and carrier types for the asynchronous SRAM host controller
package asr_pkg;
   // ==========================================
   // Geometry
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int unsigned MEM_WORDS = 524288;
   // ==========================================
   // Clock and timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int T_POWER_US = 1000;
   localparam int T_WC_NS = 17;
   localparam int T_PWE_NS = 12;
   localparam int T_SD_NS = 8;
   localparam int T_HZWE_NS = 8;
   localparam int T_RC_NS = 17;
   localparam int T_AA_NS = 17;
   localparam int T_HZ_NS = 7;
   localparam int T_PD_NS = 17;
   // Least times round up
   localparam int POWER_CYC = (T_POWER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWE_MIN = (T_PWE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SD_MIN = (T_SD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WC_MIN = ((T_HZWE_NS + T_SD_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int AA_CYC = (T_AA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HZ_CYC = (T_HZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Strobe low time: covers write pulse, data setup and release plus setup
   localparam int WR_CYC = (WC_MIN > PWE_MIN) ? WC_MIN : PWE_MIN;
   // Read wait: access time plus two cycles for the input synchroniser
   localparam int RD_CYC = AA_CYC + 2;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);
   localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
   localparam logic [CNT_W-1:0] HZ_CNT = CNT_W'(HZ_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;
   typedef struct packed {
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
   } asr_pins_t;
   localparam asr_pins_t PINS_IDLE = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
endpackage

// *** verilog/asr_pwr_wait.sv ***
// Power-up wait counter that holds off the first access
`timescale 1ns/10ps
module asr_pwr_wait #(
   parameter int POWER_CYCLES = asr_pkg::POWER_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   output logic o_ready
);
   import asr_pkg::*;
   localparam int PW = $clog2(POWER_CYCLES + 1);
   logic [PW-1:0] cnt;
   logic [PW-1:0] next_cnt;
   logic next_ready;
   // ==========================================
   // Count up to POWER_CYCLES
   always_comb begin
      next_cnt = cnt;
      next_ready = o_ready;
      if (cnt != PW'(POWER_CYCLES)) begin
         next_cnt = cnt + PW'(1);
      end else begin
         next_ready = 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cnt <= '0;
         o_ready <= 1'b0;
      end else if (i_ce) begin
         cnt <= next_cnt;
         o_ready <= next_ready;
      end
   end
endmodule

// *** verilog/asr_sync.sv ***
// Two flip-flop synchroniser for the data pins read back from the memory
`timescale 1ns/10ps
module asr_sync #(
   parameter int W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;
   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         meta <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule

// *** verilog/asr_host.sv ***
// Host controller driving a 512K x 8 asynchronous static memory
//
// Behaviour
// - Write stores data while select and write strobe are both low.
// - Read asserts select and output drive with write strobe held high.
// - Controller waits at least 1 ms after power before any access.
// - Write interval is the overlap of select and write strobe low.
// - Write data stands 8 ns before write end; hold 0 ns.
// - Write cycle at least 17 ns; strobe and setup at least 12 ns.
// - Address stable from write start until write end.
// - Strobe-controlled write with output low lasts release plus setup time.
// - Controller does not drive data while memory drives it.
// - Reads spaced 17 ns apart; data valid 17 ns after address.
// - Address is valid no later than select falling.
// - Write strobe stays high for the whole read.
// - Chip stays deselected whenever idle, so retention may begin anytime.
`timescale 1ns/10ps
module asr_host #(
   parameter int POWER_CYCLES = asr_pkg::POWER_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire asr_pkg::asr_req_t i_req,
   output logic o_req_ready,
   output logic o_rd_valid,
   output logic [asr_pkg::DATA_W-1:0] o_rd_data,
   output logic o_wr_done,
   output logic o_powered,
   output logic o_standby,
   output asr_pkg::asr_pins_t o_pins,
   output logic [asr_pkg::DATA_W-1:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [asr_pkg::DATA_W-1:0] i_dq_in
);
   import asr_pkg::*;
   // ==========================================
   // State
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_WSET = 5'b00010,
      ST_WPUL = 5'b00100,
      ST_READ = 5'b01000,
      ST_TURN = 5'b10000
   } asr_state_t;
   asr_state_t state;
   asr_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   asr_pins_t next_pins;
   logic [DATA_W-1:0] next_dq_out;
   logic next_dq_oe;
   logic next_req_ready;
   logic next_rd_valid;
   logic [DATA_W-1:0] next_rd_data;
   logic next_wr_done;
   logic next_standby;
   logic pwr_ready;
   logic [DATA_W-1:0] dq_sync;
   // ==========================================
   // Power-up wait and data input synchroniser
   asr_pwr_wait #(
      .POWER_CYCLES(POWER_CYCLES)
   ) i_asr_pwr_wait (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .o_ready(pwr_ready)
   );
   asr_sync #(
      .W(DATA_W)
   ) i_asr_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_async(i_dq_in),
      .o_sync(dq_sync)
   );
   // ==========================================
   // Sequencer
   // Writes keep output drive high throughout, so the memory never drives the
   // bus during a write and the release time need not be waited for.
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_pins = o_pins;
      next_dq_out = o_dq_out;
      next_dq_oe = o_dq_oe;
      next_req_ready = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_data = o_rd_data;
      next_wr_done = 1'b0;
      next_standby = o_standby;
      unique case (state)
         ST_IDLE: begin
            next_pins.cs_n = 1'b1;
            next_pins.oe_n = 1'b1;
            next_pins.we_n = 1'b1;
            next_standby = 1'b1;
            next_req_ready = pwr_ready && !(i_req_valid && o_req_ready);
            if (pwr_ready && i_req_valid && o_req_ready) begin
               next_req_ready = 1'b0;
               next_pins.addr = i_req.addr;
               next_standby = 1'b0;
               if (i_req.we) begin
                  // Address settles one cycle ahead of both strobes
                  next_dq_out = i_req.wdata;
                  next_dq_oe = 1'b1;
                  next_state = ST_WSET;
               end else begin
                  next_dq_oe = 1'b0;
                  next_pins.cs_n = 1'b0;
                  next_pins.oe_n = 1'b0;
                  next_pins.we_n = 1'b1;
                  next_cnt = RD_CNT;
                  next_state = ST_READ;
               end
            end
         end
         ST_WSET: begin
            next_pins.cs_n = 1'b0;
            next_pins.we_n = 1'b0;
            next_pins.oe_n = 1'b1;
            next_cnt = WR_CNT;
            next_state = ST_WPUL;
         end
         ST_WPUL: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               // Both strobes rise together; data and address held one more cycle
               next_pins.cs_n = 1'b1;
               next_pins.we_n = 1'b1;
               next_cnt = CNT_ZERO;
               next_wr_done = 1'b1;
               next_state = ST_TURN;
            end
         end
         ST_READ: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_rd_data = dq_sync;
               next_rd_valid = 1'b1;
               next_pins.cs_n = 1'b1;
               next_pins.oe_n = 1'b1;
               next_cnt = HZ_CNT;
               next_state = ST_TURN;
            end
         end
         ST_TURN: begin
            // After a read, wait for the memory to release the bus
            next_dq_oe = 1'b0;
            if (cnt > CNT_ZERO) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_standby = 1'b1;
               next_req_ready = 1'b1;
               next_state = ST_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         cnt <= CNT_ZERO;
         o_pins <= PINS_IDLE;
         o_dq_out <= '0;
         o_dq_oe <= 1'b0;
         o_req_ready <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
         o_wr_done <= 1'b0;
         o_standby <= 1'b1;
         o_powered <= 1'b0;
      end else if (i_ce) begin
         state <= next_state;
         cnt <= next_cnt;
         o_pins <= next_pins;
         o_dq_out <= next_dq_out;
         o_dq_oe <= next_dq_oe;
         o_req_ready <= next_req_ready;
         o_rd_valid <= next_rd_valid;
         o_rd_data <= next_rd_data;
         o_wr_done <= next_wr_done;
         o_standby <= next_standby;
         o_powered <= pwr_ready;
      end
   end
endmodule

// *** verification/asr_host_properties.sv ***
// Checker of the host controller pin timing
`timescale 1ns/10ps
module asr_host_properties (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic o_rd_valid,
   input wire logic o_wr_done,
   input wire logic o_powered,
   input wire logic o_standby,
   input wire asr_pkg::asr_pins_t o_pins,
   input wire logic [asr_pkg::DATA_W-1:0] o_dq_out,
   input wire logic o_dq_oe
);
   import asr_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_rd_we_high: assert property (!o_pins.cs_n && !o_pins.oe_n |-> o_pins.we_n)
      else $error("write strobe low in read");
   a_no_contention: assert property (!o_pins.oe_n |-> !o_dq_oe)
      else $error("data driven with output on");
   a_wr_overlap: assert property (!o_pins.we_n |-> !o_pins.cs_n && o_pins.oe_n)
      else $error("write strobe without select");
   a_wr_setup: assert property (!o_pins.we_n |-> o_dq_oe && $stable(o_dq_out) && $stable(o_pins.addr))
      else $error("write data or address moved");
   a_wr_end_joint: assert property ($rose(o_pins.we_n) |-> $rose(o_pins.cs_n) && o_wr_done && o_dq_oe)
      else $error("write end malformed");
   a_wr_pulse_len: assert property ($fell(o_pins.we_n) |=> o_pins.we_n)
      else $error("write pulse length wrong");
   a_early_idle: assert property (!o_powered |-> o_pins.cs_n)
      else $error("access before power wait");
   a_standby_desel: assert property (o_standby |-> o_pins.cs_n)
      else $error("standby while selected");
   a_rd_addr_hold: assert property (!o_pins.oe_n && !$past(o_pins.oe_n) |-> $stable(o_pins.addr))
      else $error("address moved in read");
   // Exact read length: strobes low three cycles, then the data is handed on
   a_rd_timing: assert property ($fell(o_pins.oe_n) |-> !o_pins.oe_n [*3] ##1 (o_rd_valid && o_pins.oe_n))
      else $error("read timing wrong");
endmodule

// *** verification/asr_sram_model.sv ***
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/10ps
module asr_sram_model (
   input wire asr_pkg::asr_pins_t i_pins,
   input wire logic [asr_pkg::DATA_W-1:0] i_dq,
   input wire logic i_slow,
   output logic o_drive,
   output logic [asr_pkg::DATA_W-1:0] o_q
);
   import asr_pkg::*;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   // Floats when deselected, output off or writing
   assign o_drive = !i_pins.cs_n && !i_pins.oe_n && i_pins.we_n;
   initial o_q = 8'h5a;
   // Garbage at once, valid 17 ns later when i_slow is set (2 ns otherwise), so early sampling fails
   always @(o_drive, i_pins.addr) begin
      o_q = ~o_q;
      if (o_drive && mem.exists(i_pins.addr))
         o_q <= #(i_slow ? 17 : 2) mem[i_pins.addr];
   end
   // Either strobe rising ends the write
   always @(posedge (i_pins.cs_n | i_pins.we_n)) begin
      if (!$isunknown(i_pins.addr))
         mem[i_pins.addr] = i_dq;
   end
endmodule

// *** verification/asr_host_tb.sv ***
// Self-checking bench for the asynchronous SRAM host controller
`timescale 1ns/10ps
module asr_host_tb;
   import asr_pkg::*;
   localparam int PWR = 20;
   logic i_sys_clk = 0, i_rst = 1, i_ce = 1, i_req_valid = 0, slow = 0;
   asr_req_t i_req = '0;
   logic o_req_ready, o_rd_valid, o_wr_done, o_powered, o_standby, o_dq_oe, drv;
   asr_pins_t o_pins;
   logic [DATA_W-1:0] o_rd_data, o_dq_out, q, dq;
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] expq [$];
   logic [31:0] seed = 32'h4363_05e3;
   int miscompares = 0, n_compared = 0, cyc = 0, nw = 0, nd = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   // Resolved data lines
   assign dq = o_dq_oe ? o_dq_out : q;
   asr_host #(.POWER_CYCLES(PWR)) i_asr_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_wr_done(o_wr_done),
      .o_powered(o_powered), .o_standby(o_standby), .o_pins(o_pins),
      .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq));
   asr_sram_model i_asr_sram_model (.i_pins(o_pins), .i_dq(dq), .i_slow(slow),
      .o_drive(drv), .o_q(q));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Holds the request until the edge that takes it, then notes the expectation
   task automatic req(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      #2;
      i_req_valid = 1;
      i_req = '{we: we, addr: a, wdata: d};
      do @(posedge i_sys_clk); while (o_req_ready !== 1'b1);
      if (we) begin
         shadow[a] = d;
         nw++;
      end else
         expq.push_back(shadow[a]);
      #2;
      i_req_valid = 0;
   endtask
   always @(posedge i_sys_clk) begin
      if (o_wr_done === 1'b1)
         nd++;
      if (o_rd_valid === 1'b1)
         chk("rd_data", expq.size() > 0 ? expq.pop_front() : 8'hxx, o_rd_data);
   end
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      repeat (8) @(posedge i_sys_clk);
      #2;
      i_rst = 0;
      i_ce = 0;
      repeat (PWR + 5) @(posedge i_sys_clk);
      chk("powered", 8'h00, {7'h0, o_powered});
      #2;
      i_ce = 1;
      repeat (PWR - 1) @(posedge i_sys_clk);
      chk("powered", 8'h00, {7'h0, o_powered});
      repeat (5) @(posedge i_sys_clk);
      chk("powered", 8'h01, {7'h0, o_powered});
      slow = 1;
      req(1, '0, 8'h00);
      req(1, 19'h7_ffff, 8'hff);
      req(0, '0, 8'h00);
      req(0, 19'h7_ffff, 8'h00);
      req(1, 19'h7_ffff, 8'ha5);
      req(0, 19'h7_ffff, 8'h00);
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         slow = seed[31];
         req(1, seed[18:0], seed[26:19]);
         req(0, seed[18:0], 8'h00);
         if (seed[30])
            req(0, '0, 8'h00);
      end
      repeat (10) @(posedge i_sys_clk);
      chk("wr_done", nw[7:0], nd[7:0]);
      chk("pending", 8'h00, expq.size());
      end_sim();
   end
endmodule
bind asr_host asr_host_properties i_asr_host_properties (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done), .o_powered(o_powered),
   .o_standby(o_standby), .o_pins(o_pins), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
